/* File: rtl/acsm_audio_clock_source_mux.sv */
// Top of the audio clock source selector: two selection registers on the
// control port and three glitch-free clock selectors.
// Assumes clock sources arrive asynchronously and run well below core_clk/2.
`timescale 1ns/1ns

module acsm_audio_clock_source_mux (
  input  wire logic                      core_clk,
  input  wire logic                      sys_rst,
  input  wire logic                      clkEn,
  input  wire logic                      regWrEn,
  input  wire logic                      regRdEn,
  input  wire logic [7:0]                regAddr,
  input  wire logic [7:0]                regWrData,
  output logic      [7:0]                regRdData,
  input  wire acsm_pkg::acsm_clocks_type clockPins,
  output logic                           prescalerInputClock,
  output logic                           firstPortBitclkDividerClock,
  output logic                           secondPortBitclkDividerClock
);

  typedef struct packed {
    acsm_pkg::acsm_clocks_type syncA;
    acsm_pkg::acsm_clocks_type syncB;
    logic [7:0]                clockSourceSelectPrimary;
    logic [7:0]                clockSourceSelectSecondary;
    logic [7:0]                rdData;
  } acsm_top_state_type;

  acsm_top_state_type      st;
  acsm_top_state_type      next_st;
  acsm_pkg::acsm_pick_type preReq;
  acsm_pkg::acsm_pick_type firstReq;
  acsm_pkg::acsm_pick_type secondReq;

  ////////////////////////////////////////////////////////////////////////////////
  // Register port and pin synchronisers
  always_comb
  begin
    next_st       = st;
    next_st.syncA = clockPins;
    next_st.syncB = st.syncA;
    if (regWrEn && regAddr == acsm_pkg::PRIMARY_SEL_OFFSET)
    begin
      next_st.clockSourceSelectPrimary = regWrData & acsm_pkg::PRIMARY_SEL_MASK;
    end
    if (regWrEn && regAddr == acsm_pkg::SECONDARY_SEL_OFFSET)
    begin
      next_st.clockSourceSelectSecondary = regWrData & acsm_pkg::SECONDARY_SEL_MASK;
    end
    if (regRdEn)
    begin
      case (regAddr)
        acsm_pkg::PRIMARY_SEL_OFFSET:   next_st.rdData = st.clockSourceSelectPrimary;
        acsm_pkg::SECONDARY_SEL_OFFSET: next_st.rdData = st.clockSourceSelectSecondary;
        default:                        next_st.rdData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      st                            <= '0;
      st.clockSourceSelectPrimary   <= acsm_pkg::PRIMARY_SEL_RESET;
      st.clockSourceSelectSecondary <= acsm_pkg::SECONDARY_SEL_RESET;
    end
    else if (clkEn)
    begin
      st <= next_st;
    end
  end

  assign regRdData = st.rdData;

  ////////////////////////////////////////////////////////////////////////////////
  // Source decoding and selectors
  assign preReq    = acsm_pkg::acsm_decode_prescaler(
                       st.clockSourceSelectPrimary[acsm_pkg::PRESCALER_SEL_LSB +: 2]);
  assign firstReq  = acsm_pkg::acsm_decode_divider(
                       st.clockSourceSelectPrimary[acsm_pkg::FIRST_DIV_SEL_LSB +: 3], 1'b0);
  assign secondReq = acsm_pkg::acsm_decode_divider(
                       st.clockSourceSelectSecondary[acsm_pkg::SECOND_DIV_SEL_LSB +: 3], 1'b1);

  acsm_clock_select #(
    .RESET_IDX (acsm_pkg::SRC_FIRST_BITCLK)
  ) u_prescaler_sel (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .clkEn     (clkEn),
    .srcLevels (st.syncB),
    .request   (preReq),
    .clkOut    (prescalerInputClock)
  );

  acsm_clock_select #(
    .RESET_IDX (acsm_pkg::SRC_PLL)
  ) u_first_div_sel (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .clkEn     (clkEn),
    .srcLevels (st.syncB),
    .request   (firstReq),
    .clkOut    (firstPortBitclkDividerClock)
  );

  acsm_clock_select #(
    .RESET_IDX (acsm_pkg::SRC_PLL)
  ) u_second_div_sel (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .clkEn     (clkEn),
    .srcLevels (st.syncB),
    .request   (secondReq),
    .clkOut    (secondPortBitclkDividerClock)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_reset_values;
    @(posedge core_clk) sys_rst |=> st.clockSourceSelectPrimary == 8'h00 && st.clockSourceSelectSecondary == 8'h00;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("Select registers not cleared by reset");

  property p_primary_write;
    @(posedge core_clk) disable iff (sys_rst)
      (clkEn && regWrEn && regAddr == 8'h32) |=> st.clockSourceSelectPrimary == ($past(regWrData) & 8'hf8);
  endproperty
  a_primary_write: assert property (p_primary_write) else $error("First register write lost");

  property p_secondary_readback;
    @(posedge core_clk) disable iff (sys_rst)
      (clkEn && regRdEn && regAddr == 8'h33) |=> regRdData[7] == 1'b0 && regRdData[3:0] == 4'h0
        && regRdData == $past(st.clockSourceSelectSecondary);
  endproperty
  a_secondary_readback: assert property (p_secondary_readback) else $error("Second register readback wrong");

  property p_prescaler_ctrl_pin;
    @(posedge core_clk) disable iff (sys_rst)
      st.clockSourceSelectPrimary[7:6] == 2'h2 |-> preReq.idx == acsm_pkg::SRC_CTRL_PIN;
  endproperty
  a_prescaler_ctrl_pin: assert property (p_prescaler_ctrl_pin) else $error("Prescaler source mismatch");

  property p_first_reserved;
    @(posedge core_clk) disable iff (sys_rst)
      st.clockSourceSelectPrimary[5:3] == 3'h1 |-> !firstReq.valid;
  endproperty
  a_first_reserved: assert property (p_first_reserved) else $error("Reserved first code selected a source");

  property p_second_pll;
    @(posedge core_clk) disable iff (sys_rst)
      st.clockSourceSelectSecondary[6:4] == 3'h0 |-> secondReq.valid && secondReq.idx == acsm_pkg::SRC_PLL;
  endproperty
  a_second_pll: assert property (p_second_pll) else $error("Second divider not on PLL");

  property p_second_write;
    @(posedge core_clk) disable iff (sys_rst)
      (clkEn && regWrEn && regAddr == 8'h33) |=> st.clockSourceSelectSecondary == ($past(regWrData) & 8'h70);
  endproperty
  a_second_write: assert property (p_second_write) else $error("Second register write lost");

  property p_primary_readback;
    @(posedge core_clk) disable iff (sys_rst)
      (clkEn && regRdEn && regAddr == 8'h32) |=> regRdData[2:0] == 3'h0
        && regRdData == $past(st.clockSourceSelectPrimary);
  endproperty
  a_primary_readback: assert property (p_primary_readback) else $error("First register readback wrong");

  property p_unmapped_read;
    @(posedge core_clk) disable iff (sys_rst)
      (clkEn && regRdEn && regAddr != 8'h32 && regAddr != 8'h33) |=> regRdData == 8'h00;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("Unmapped read not zero");

  property p_frozen_hold;
    @(posedge core_clk) disable iff (sys_rst)
      !clkEn |=> $stable(st.clockSourceSelectPrimary) && $stable(st.clockSourceSelectSecondary)
        && $stable(regRdData);
  endproperty
  a_frozen_hold: assert property (p_frozen_hold) else $error("Registers changed while frozen");

  property p_outputs_reset;
    @(posedge core_clk) sys_rst |=> !prescalerInputClock && !firstPortBitclkDividerClock
      && !secondPortBitclkDividerClock;
  endproperty
  a_outputs_reset: assert property (p_outputs_reset) else $error("Clock outputs not low after reset");

  property p_pre_first;
    @(posedge core_clk) disable iff (sys_rst)
      st.clockSourceSelectPrimary[7:6] == 2'h0 |-> preReq.valid && preReq.idx == acsm_pkg::SRC_FIRST_BITCLK;
  endproperty
  a_pre_first: assert property (p_pre_first) else $error("Prescaler not on first bit clock");

  property p_first_osc;
    @(posedge core_clk) disable iff (sys_rst)
      st.clockSourceSelectPrimary[5:3] == 3'h4 |-> firstReq.valid && firstReq.idx == acsm_pkg::SRC_OSC;
  endproperty
  a_first_osc: assert property (p_first_osc) else $error("First divider not on oscillator");

  property p_first_second;
    @(posedge core_clk) disable iff (sys_rst)
      st.clockSourceSelectPrimary[5:3] == 3'h2 |-> firstReq.valid && firstReq.idx == acsm_pkg::SRC_SECOND_BITCLK;
  endproperty
  a_first_second: assert property (p_first_second) else $error("First divider not on second bit clock");

  property p_second_first;
    @(posedge core_clk) disable iff (sys_rst)
      st.clockSourceSelectSecondary[6:4] == 3'h1 |-> secondReq.valid
        && secondReq.idx == acsm_pkg::SRC_FIRST_BITCLK;
  endproperty
  a_second_first: assert property (p_second_first) else $error("Second divider not on first bit clock");

  property p_second_reserved;
    @(posedge core_clk) disable iff (sys_rst)
      st.clockSourceSelectSecondary[6:4] == 3'h2 |-> !secondReq.valid;
  endproperty
  a_second_reserved: assert property (p_second_reserved) else $error("Reserved second code selected a source");

endmodule

/* File: rtl/acsm_pkg.sv */
// Package for the audio clock source selector: register map, field layout,
// source indices and the code-to-source decoders.
// Assumes all users reference items as acsm_pkg::name.
package acsm_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [7:0] PRIMARY_SEL_OFFSET   = 8'h32;
  localparam logic [7:0] SECONDARY_SEL_OFFSET = 8'h33;
  localparam logic [7:0] PRIMARY_SEL_RESET    = 8'h00;
  localparam logic [7:0] SECONDARY_SEL_RESET  = 8'h00;
  localparam logic [7:0] PRIMARY_SEL_MASK     = 8'hf8;
  localparam logic [7:0] SECONDARY_SEL_MASK   = 8'h70;
  localparam int         PRESCALER_SEL_LSB    = 6;
  localparam int         FIRST_DIV_SEL_LSB    = 3;
  localparam int         SECOND_DIV_SEL_LSB   = 4;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock sources
  typedef enum logic [2:0] {
    SRC_FIRST_BITCLK,
    SRC_SECOND_BITCLK,
    SRC_CTRL_PIN,
    SRC_OSC,
    SRC_PLL,
    SRC_DSP
  } acsm_src_type;

  localparam int SRC_COUNT = 6;

  typedef struct packed {
    logic dspClk;
    logic pllOutClk;
    logic oscClk;
    logic controllerClockPin;
    logic secondBitClk;
    logic firstBitClk;
  } acsm_clocks_type;

  typedef struct packed {
    logic         valid;
    acsm_src_type idx;
  } acsm_pick_type;

  ////////////////////////////////////////////////////////////////////////////////
  // Decoders from register codes to source picks
  function automatic acsm_pick_type acsm_decode_prescaler(input logic [1:0] code);
    acsm_pick_type p;
    p.valid = 1'b1;
    case (code)
      2'h0:    p.idx = SRC_FIRST_BITCLK;
      2'h1:    p.idx = SRC_SECOND_BITCLK;
      2'h2:    p.idx = SRC_CTRL_PIN;
      default: p.idx = SRC_OSC;
    endcase
    return p;
  endfunction

  function automatic acsm_pick_type acsm_decode_divider(input logic [2:0] code, input logic second);
    acsm_pick_type p;
    p.valid = 1'b1;
    p.idx   = SRC_PLL;
    case (code)
      3'h0:    p.idx = SRC_PLL;
      3'h1:    p.idx = SRC_FIRST_BITCLK;
      3'h2:    p.idx = SRC_SECOND_BITCLK;
      3'h3:    p.idx = SRC_CTRL_PIN;
      3'h4:    p.idx = SRC_OSC;
      3'h5:    p.idx = SRC_DSP;
      default: p.valid = 1'b0;
    endcase
    // Each divider cannot take its own bit clock
    if ((code == 3'h1 && !second) || (code == 3'h2 && second))
    begin
      p.valid = 1'b0;
    end
    return p;
  endfunction

endpackage

/* File: rtl/acsm_clock_select.sv */
// Glitch-free selector of one clock out of the synchronised source levels.
// Assumes source levels are already synchronised to core_clk.
`timescale 1ns/1ns
module acsm_clock_select #(
  parameter acsm_pkg::acsm_src_type RESET_IDX = acsm_pkg::SRC_PLL
) (
  input  wire logic                      core_clk,
  input  wire logic                      sys_rst,
  input  wire logic                      clkEn,
  input  wire logic [acsm_pkg::SRC_COUNT-1:0] srcLevels,
  input  wire acsm_pkg::acsm_pick_type   request,
  output logic                           clkOut
);

  typedef struct packed {
    acsm_pkg::acsm_pick_type cur;
    logic                    outLvl;
  } acsm_sel_state_type;

  acsm_sel_state_type st;
  acsm_sel_state_type next_st;
  logic               reqDiff;

  ////////////////////////////////////////////////////////////////////////////////
  // Switch only while the output is low and the new source is low or the request is invalid
  always_comb
  begin
    next_st = st;
    reqDiff = (request != st.cur);
    if (reqDiff && !st.outLvl)
    begin
      next_st.outLvl = 1'b0;
      if (!request.valid || !srcLevels[request.idx])
      begin
        next_st.cur = request;
      end
    end
    else
    begin
      next_st.outLvl = st.cur.valid & srcLevels[st.cur.idx];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      st.cur.valid <= 1'b1;
      st.cur.idx   <= RESET_IDX;
      st.outLvl    <= 1'b0;
    end
    else if (clkEn)
    begin
      st <= next_st;
    end
  end

  assign clkOut = st.outLvl;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_hold_while_high;
    @(posedge core_clk) disable iff (sys_rst)
      (clkEn && reqDiff && st.outLvl) |=> $stable(st.cur);
  endproperty
  a_hold_while_high: assert property (p_hold_while_high) else $error("Source switched while output high");

  property p_low_during_switch;
    @(posedge core_clk) disable iff (sys_rst)
      (clkEn && reqDiff && !st.outLvl) |=> !st.outLvl;
  endproperty
  a_low_during_switch: assert property (p_low_during_switch) else $error("Output rose during switch");

endmodule

/* File: test/acsm_testbench.sv */
// Self-checking testbench for the audio clock source selector top.
// Assumes acsm_pkg is compiled first; the bench drives every port itself.
`timescale 1ns/1ns
module testbench;
  logic                      core_clk;
  logic                      sys_rst;
  logic                      clkEn;
  logic                      regWrEn;
  logic                      regRdEn;
  logic [7:0]                regAddr;
  logic [7:0]                regWrData;
  logic [7:0]                regRdData;
  acsm_pkg::acsm_clocks_type clockPins;
  wire  [2:0]                outs;
  logic [7:0]                rdVal;
  int                        failCount;
  int                        cmpCount;
  int                        preMap[4]    = '{0, 1, 2, 3};
  int                        firstMap[8]  = '{4, -1, 1, 2, 3, 5, -1, -1};
  int                        secondMap[8] = '{4, 0, -1, 2, 3, 5, -1, -1};

  ////////////////////////////////////////////////////////////////////////////////
  acsm_audio_clock_source_mux dut (
    .core_clk                     (core_clk),
    .sys_rst                      (sys_rst),
    .clkEn                        (clkEn),
    .regWrEn                      (regWrEn),
    .regRdEn                      (regRdEn),
    .regAddr                      (regAddr),
    .regWrData                    (regWrData),
    .regRdData                    (regRdData),
    .clockPins                    (clockPins),
    .prescalerInputClock          (outs[0]),
    .firstPortBitclkDividerClock  (outs[1]),
    .secondPortBitclkDividerClock (outs[2])
  );

  always #50 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmpCount++;
    if (got !== exp)
    begin
      failCount++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_level(input string name, input logic exp, input logic got);
    cmpCount++;
    if (got !== exp)
    begin
      failCount++;
      $display("ERROR %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #10;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cyc(1);
    regWrEn = 1'b1;
    regAddr = a;
    regWrData = d;
    cyc(1);
    regWrEn = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    cyc(1);
    regRdEn = 1'b1;
    regAddr = a;
    cyc(1);
    regRdEn = 1'b0;
    rdVal = regRdData;
  endtask

  // Only the expected pin toggles high; every other source is held high first
  task automatic route(input logic [7:0] a, input int lsb, input int code, input int sel, input int pin);
    logic [5:0] m;
    m = (pin < 0) ? 6'h00 : 6'h01 << pin;
    clockPins = 6'h00;
    wr(a, 8'(code << lsb));
    cyc(6);
    clockPins = ~m;
    cyc(6);
    check_level("output with other sources high", 1'b0, outs[sel]);
    clockPins = m;
    cyc(6);
    check_level("output with chosen source high", pin >= 0, outs[sel]);
    clockPins = 6'h00;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_reset_state();
    rd(8'h32);
    check_byte("first select reset", 8'h00, rdVal);
    rd(8'h33);
    check_byte("second select reset", 8'h00, rdVal);
    clockPins = 6'h11;
    cyc(6);
    check_byte("reset routing high", 8'h07, {5'h00, outs});
    clockPins = 6'h2e;
    cyc(6);
    check_byte("reset routing low", 8'h00, {5'h00, outs});
    clockPins = 6'h00;
  endtask

  task automatic test_unused_bits();
    wr(8'h32, 8'hff);
    rd(8'h32);
    check_byte("first select unused bits", 8'hf8, rdVal);
    wr(8'h33, 8'hff);
    wr(8'h34, 8'h55);
    rd(8'h33);
    check_byte("second select unused bits", 8'h70, rdVal);
    rd(8'h40);
    check_byte("unmapped read", 8'h00, rdVal);
    rd(8'h32);
    check_byte("first select after unmapped write", 8'hf8, rdVal);
    wr(8'h33, 8'h00);
  endtask

  task automatic test_frozen_and_reset();
    wr(8'h32, 8'h00);
    clkEn = 1'b0;
    wr(8'h32, 8'h40);
    clkEn = 1'b1;
    rd(8'h32);
    check_byte("write while frozen", 8'h00, rdVal);
    wr(8'h32, 8'h58);
    wr(8'h33, 8'h50);
    sys_rst = 1'b1;
    cyc(2);
    sys_rst = 1'b0;
    rd(8'h32);
    check_byte("first select after reset", 8'h00, rdVal);
    rd(8'h33);
    check_byte("second select after reset", 8'h00, rdVal);
  endtask

  task automatic test_routing();
    for (int c = 0; c < 4; c++) route(8'h32, 6, c, 0, preMap[c]);
    for (int c = 0; c < 8; c++) route(8'h32, 3, c, 1, firstMap[c]);
    for (int c = 0; c < 8; c++) route(8'h33, 4, c, 2, secondMap[c]);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmpCount, failCount);
    if (failCount == 0 && cmpCount > 0)
    begin
      $display("[ PASS ]");
    end
    else
    begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial
  begin
    core_clk = 1'b0;
    sys_rst = 1'b1;
    clkEn = 1'b1;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    clockPins = 6'h00;
    failCount = 0;
    cmpCount = 0;
    cyc(20);
    sys_rst = 1'b0;
    test_reset_state();
    test_unused_bits();
    test_routing();
    test_frozen_and_reset();
    print_verdict();
  end

  initial
  begin
    #(100 * 6000);
    failCount++;
    print_verdict();
  end
endmodule
